// ### ftb_cfg.svh
`ifndef FTB_CFG_SVH
`define FTB_CFG_SVH
// ==========================================
// geometry and reset values
`define FTB_DEPTH       16
`define FTB_WIDTH       5
`define FTB_IDX_W       4
`define FTB_CNT_W       5
`define FTB_SYNC_RST    3'h7
`define FTB_VAC_PULSE_CYC 1
`endif

// ### ftb_pkg.sv
package ftb_pkg;
    // ==========================================
    // word and pin group types
    typedef logic [4:0] ftb_word_t;
    typedef struct packed {
        logic      load_clock_a;
        logic      load_clock_b;
        logic      unload_clock_in;
        logic      clear_all_n;
    } ftb_pins_t;
    typedef struct packed {
        ftb_word_t data;
        logic      data_oe_n;
    } ftb_dout_t;
endpackage

// ### ftb_fifo.sv
`include "ftb_cfg.svh"
// ==========================================
// fall-through storage, parameterised width and depth
module ftb_fifo
    import ftb_pkg::*;
#(
    parameter int WIDTH = `FTB_WIDTH,
    parameter int DEPTH = `FTB_DEPTH
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_i,
    input  wire logic             clr_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o,
    output logic [$clog2(DEPTH+1)-1:0] count_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [$clog2(DEPTH+1)-1:0] cnt;
    logic             do_wr;
    logic             do_rd;

    // handshake decode
    assign in_ready_o  = (cnt != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign out_valid_o = (cnt != '0);
    assign do_wr       = in_valid_i & in_ready_o;
    assign do_rd       = out_ready_i & out_valid_o;
    assign out_data_o  = mem[rd_ptr];
    assign count_o     = cnt;

    // pointers and fill count
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            cnt    <= '0;
        end else if (clr_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            cnt    <= '0;
        end else begin
            if (do_wr)
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            if (do_rd)
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            cnt <= cnt + {{($clog2(DEPTH+1)-1){1'b0}}, do_wr} - {{($clog2(DEPTH+1)-1){1'b0}}, do_rd};
        end
    end

    // storage array, no reset on data
    always_ff @(posedge ref_clk_i) begin
        if (do_wr)
            mem[wr_ptr] <= in_data_i;
    end
endmodule

// ### ftb_top.sv
// Function
// - sixteen words of five bits stored
// - status pins allow depth/width cascading
// - load on rising edge of either clock
// - unload on unload clock rising edge
// - gate high lets next clock load
// - both load clocks treated symmetrically
// - input ready high unless memory full
// - low vacancy pulse when last location frees
// - output ready needs valid word, unload high
// - unload fall drops output ready
// - oldest word drives data outputs
// - outputs keep input polarity
// - enable low drives data outputs
// - enable high floats data, status runs
// - clear falling edge empties, drops ready
`include "ftb_cfg.svh"
module ftb_top
    import ftb_pkg::*;
#(
    parameter int WIDTH = `FTB_WIDTH,
    parameter int DEPTH = `FTB_DEPTH
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_i,
    input  wire logic             load_clock_a_i,
    input  wire logic             load_clock_b_i,
    input  wire logic             unload_clock_in_i,
    input  wire logic             clear_all_n_i,
    input  wire logic             data_oe_n_i,
    input  wire logic [WIDTH-1:0] data_i,
    output logic [WIDTH-1:0]      data_o,
    output logic [WIDTH-1:0]      data_oe_n_o,
    output logic                  input_ready_o,
    output logic                  output_ready_o,
    output logic                  vacancy_pulse_out_o
);
    localparam int CW = $clog2(DEPTH+1);

    // ==========================================
    // pin synchronisers: three stages, change seen when stages 2 and 3 agree
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_u;
    logic [2:0] sync_c;
    logic [2:0] sync_oe;
    logic [WIDTH-1:0] data_s1;
    logic [WIDTH-1:0] data_s2;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_a  <= `FTB_SYNC_RST;
            sync_b  <= `FTB_SYNC_RST;
            sync_u  <= `FTB_SYNC_RST;
            sync_c  <= `FTB_SYNC_RST;
            sync_oe <= `FTB_SYNC_RST;
        end else begin
            sync_a  <= {sync_a[1:0], load_clock_a_i};
            sync_b  <= {sync_b[1:0], load_clock_b_i};
            sync_u  <= {sync_u[1:0], unload_clock_in_i};
            sync_c  <= {sync_c[1:0], clear_all_n_i};
            sync_oe <= {sync_oe[1:0], data_oe_n_i};
        end
    end

    // data bus sampled twice so it is stable when a load edge is seen
    always_ff @(posedge ref_clk_i) begin
        data_s1 <= data_i;
        data_s2 <= data_s1;
    end

    // filtered levels: hold old value until stages 2 and 3 agree
    logic lvl_a;
    logic lvl_b;
    logic lvl_u;
    logic lvl_c;
    logic lvl_oe;
    logic next_lvl_a;
    logic next_lvl_b;
    logic next_lvl_u;
    logic next_lvl_c;
    logic next_lvl_oe;

    assign next_lvl_a  = (sync_a[2] == sync_a[1]) ? sync_a[2] : lvl_a;
    assign next_lvl_b  = (sync_b[2] == sync_b[1]) ? sync_b[2] : lvl_b;
    assign next_lvl_u  = (sync_u[2] == sync_u[1]) ? sync_u[2] : lvl_u;
    assign next_lvl_c  = (sync_c[2] == sync_c[1]) ? sync_c[2] : lvl_c;
    assign next_lvl_oe = (sync_oe[2] == sync_oe[1]) ? sync_oe[2] : lvl_oe;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lvl_a  <= 1'b1;
            lvl_b  <= 1'b1;
            lvl_u  <= 1'b1;
            lvl_c  <= 1'b1;
            lvl_oe <= 1'b1;
        end else begin
            lvl_a  <= next_lvl_a;
            lvl_b  <= next_lvl_b;
            lvl_u  <= next_lvl_u;
            lvl_c  <= next_lvl_c;
            lvl_oe <= next_lvl_oe;
        end
    end

    // ==========================================
    // edge decode
    logic rise_a;
    logic rise_b;
    logic rise_u;
    logic fall_u;
    logic fall_c;
    logic load_edge;

    assign rise_a    = next_lvl_a & ~lvl_a;
    assign rise_b    = next_lvl_b & ~lvl_b;
    assign rise_u    = next_lvl_u & ~lvl_u;
    assign fall_u    = ~next_lvl_u & lvl_u;
    assign fall_c    = ~next_lvl_c & lvl_c;
    // either input clocks while the other gates; gate low blocks the load
    assign load_edge = (rise_a & next_lvl_b) | (rise_b & next_lvl_a);

    // ==========================================
    // storage, fall-through toward the output location
    logic             fifo_in_ready;
    logic             fifo_out_valid;
    logic [WIDTH-1:0] fifo_out_data;
    logic [CW-1:0]    fifo_count;
    logic             unload_take;

    // output ready is already low while unload is low, so the rise is gated by
    // a valid head word only; an empty store drops the unload
    assign unload_take = rise_u & fifo_out_valid;

    ftb_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_store (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .clr_i       (fall_c),
        .in_valid_i  (load_edge),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (data_s2),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (unload_take),
        .out_data_o  (fifo_out_data),
        .count_o     (fifo_count)
    );

    // ==========================================
    // status flags
    logic or_arm;
    logic was_full;
    logic vac_pulse;

    // output ready re-arms once a word sits at the head; unload fall drops it
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            or_arm <= 1'b0;
        else if (fall_c)
            or_arm <= 1'b0;
        else if (fall_u | unload_take)
            or_arm <= 1'b0;
        else if (fifo_out_valid & lvl_u)
            or_arm <= 1'b1;
    end

    assign output_ready_o = or_arm & fifo_out_valid & lvl_u;

    // input ready follows the last location
    assign input_ready_o = fifo_in_ready;

    // vacancy pulse on the full-to-not-full step, one clock low
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            was_full  <= 1'b0;
            vac_pulse <= 1'b0;
        end else begin
            was_full  <= ~fifo_in_ready;
            vac_pulse <= was_full & fifo_in_ready;
        end
    end

    assign vacancy_pulse_out_o = ~vac_pulse;

    // ==========================================
    // output drivers: head word, same polarity, common enable
    logic [WIDTH-1:0] q_reg;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            q_reg <= '0;
        else
            q_reg <= fifo_out_data;
    end

    assign data_o      = q_reg;
    assign data_oe_n_o = {WIDTH{lvl_oe}};

    // ==========================================
    // checks
    sequence s_unload_fall;
        lvl_u ##1 ~lvl_u;
    endsequence

    a_ir_full: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        input_ready_o == (fifo_count != CW'(DEPTH)))
        else $error("input ready disagrees with fill");
    a_count_max: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        fifo_count <= CW'(DEPTH))
        else $error("fill exceeds depth");
    a_or_fall: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_unload_fall |-> ~output_ready_o)
        else $error("output ready high after unload fall");
    a_or_valid: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        output_ready_o |-> (fifo_out_valid && lvl_u))
        else $error("output ready without data or unload high");
    a_clr_empty: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        fall_c |=> (fifo_count == '0 && !output_ready_o))
        else $error("clear did not empty");
    a_load_grow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (load_edge && input_ready_o && !unload_take && !fall_c)
        |=> fifo_count == $past(fifo_count) + 1'b1)
        else $error("load edge lost");
    a_full_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!input_ready_o && !unload_take && !fall_c) |=> !input_ready_o)
        else $error("full store changed without unload");
    a_vac_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!fifo_in_ready ##1 fifo_in_ready) |=> !vacancy_pulse_out_o ##1 vacancy_pulse_out_o)
        else $error("vacancy pulse missing");
    a_gate_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!next_lvl_a && !next_lvl_b) |-> !load_edge)
        else $error("load with both inputs low");
    a_oe_float: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        lvl_oe |-> data_oe_n_o == {WIDTH{1'b1}})
        else $error("outputs driven while disabled");

    // ==========================================
    // transfer steps: taken, blocked and refused edges
    sequence s_load_taken;
        load_edge && input_ready_o && !unload_take && !fall_c;
    endsequence

    sequence s_unload_taken;
        unload_take && !load_edge && !fall_c;
    endsequence

    sequence s_load_blocked;
        load_edge && !input_ready_o && !unload_take && !fall_c;
    endsequence

    sequence s_unload_blocked;
        rise_u && !fifo_out_valid && !load_edge && !fall_c;
    endsequence

    // count follows every taken or blocked edge
    a_unload_shrink: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_unload_taken |=> fifo_count == $past(fifo_count) - 1'b1)
        else $error("unload edge did not remove a word");
    a_load_blocked: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_load_blocked |=> fifo_count == $past(fifo_count))
        else $error("load into full store changed fill");
    a_unload_blocked: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_unload_blocked |=> fifo_count == '0)
        else $error("unload of empty store changed fill");
    a_ir_return: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (s_unload_taken and (!input_ready_o)) |=> input_ready_o)
        else $error("input ready stayed low after unload");

    // a word loaded into an empty store reaches the head on its own
    a_load_head: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (s_load_taken and (fifo_count == '0)) |=> fifo_out_data == $past(data_s2))
        else $error("loaded word not at head");
    a_or_rearm: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (fifo_out_valid && lvl_u && !or_arm && !fall_c && !fall_u && !unload_take) |=> output_ready_o)
        else $error("output ready not raised for head word");

    // data outputs carry the head word one clock later, unchanged
    a_head_word: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(fifo_out_valid) |-> data_o == $past(fifo_out_data))
        else $error("data outputs differ from head word");
    a_oe_drive: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !lvl_oe |-> data_oe_n_o == '0)
        else $error("outputs floating while enabled");

    // clear leaves room for a full store again
    a_clear_ready: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        fall_c |=> input_ready_o)
        else $error("input ready low after clear");

    // vacancy pulse only after the full-to-not-full step
    a_vac_cause: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !vacancy_pulse_out_o |-> ($past(input_ready_o) && !$past(input_ready_o, 2)))
        else $error("vacancy pulse without leaving full");

    // either load input clocks while the other gates, and only then
    a_gate_a_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rise_a && !next_lvl_b) |-> !load_edge)
        else $error("load on a with gate b low");
    a_gate_b_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rise_b && !next_lvl_a) |-> !load_edge)
        else $error("load on b with gate a low");
    a_clock_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rise_a && next_lvl_b) |-> load_edge)
        else $error("gated rise on a not taken");
    a_clock_b: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rise_b && next_lvl_a) |-> load_edge)
        else $error("gated rise on b not taken");
endmodule

// ### ftb_partner.sv
// ==========================================
// writing and reading systems beside the block
module ftb_partner
    import ftb_pkg::*;
(
    input  wire logic  ref_clk_i,
    output logic [1:0] load_pins_o,
    output logic       unload_o,
    output ftb_word_t  data_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle: a is the clock (low), b is the gate (high)
    initial begin
        load_pins_o = 2'b10;
        unload_o    = 1'b1;
        data_o      = 5'h00;
    end

    // three more edges, then step off the edge
    task automatic wait3();
        repeat (3) @(posedge ref_clk_i);
        #1;
    endtask

    // clock pin falls, gate takes its level, clock pulses once
    task automatic load(input ftb_word_t w, input logic via_b, input logic gate);
        @(posedge ref_clk_i);
        load_pins_o[via_b] <= 1'b0;
        data_o             <= w;
        wait3();
        @(posedge ref_clk_i);
        load_pins_o[!via_b] <= gate;
        wait3();
        @(posedge ref_clk_i);
        load_pins_o[via_b] <= 1'b1;
        wait3();
        @(posedge ref_clk_i);
        load_pins_o[via_b] <= 1'b0;
        wait3();
        @(posedge ref_clk_i);
        data_o <= ~w; // hold over, data no longer kept
        #1;
    endtask

    // the fall is seen three edges on and drops output ready one edge later
    task automatic unload_low();
        @(posedge ref_clk_i);
        unload_o <= 1'b0;
        wait3();
        wait3();
    endtask

    // rise removes the head, then time for the next to fall through
    task automatic unload_high();
        @(posedge ref_clk_i);
        unload_o <= 1'b1;
        wait3();
        wait3();
    endtask
endmodule

// ### ftb_top_tb.sv
// ==========================================
// self-checking bench for the fall-through buffer
module ftb_top_tb
    import ftb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic       ref_clk_i;
    logic       rst_i;
    logic       clear_all_n;
    logic       data_oe_n;
    logic [1:0] load_pins;
    logic       unload;
    ftb_word_t  data_in;
    ftb_word_t  data_out;
    logic [4:0] oe_n;
    logic       input_ready;
    logic       output_ready;
    logic       vacancy;
    int         errors;
    int         n_checks;
    int         vac_lows;

    ftb_top dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .load_clock_a_i(load_pins[0]), .load_clock_b_i(load_pins[1]),
        .unload_clock_in_i(unload), .clear_all_n_i(clear_all_n), .data_oe_n_i(data_oe_n), .data_i(data_in),
        .data_o(data_out), .data_oe_n_o(oe_n), .input_ready_o(input_ready), .output_ready_o(output_ready),
        .vacancy_pulse_out_o(vacancy));

    ftb_partner p (.ref_clk_i(ref_clk_i), .load_pins_o(load_pins), .unload_o(unload), .data_o(data_in));

    // ==========================================
    // clock, vacancy watcher, helpers
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) if (!rst_i && vacancy === 1'b0) vac_lows++;

    function automatic ftb_word_t wd(input int i);
        return 5'(i * 7 + 3);
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic done(input string name);
        $display("test %s done, errors=%0d", name, errors);
    endtask

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        chk(input_ready, 1'b1);
        chk(output_ready, 1'b0);
        chk(vacancy, 1'b1);
        chk(oe_n, 5'h1f);
        done("reset");
    endtask

    // fill through both clock pins, refuse the 17th, drain in order
    task automatic t_fill_drain();
        for (int i = 0; i < 16; i++) p.load(wd(i), i[0], 1'b1);
        chk(input_ready, 1'b0);
        p.load(5'h15, 1'b0, 1'b1);
        vac_lows = 0;
        for (int i = 0; i < 16; i++) begin
            chk(output_ready, 1'b1);
            chk(data_out, wd(i));
            p.unload_low();
            chk(output_ready, 1'b0);
            p.unload_high();
            chk(input_ready, 1'b1);
        end
        chk(8'(vac_lows), 8'h01);
        chk(output_ready, 1'b0);
        p.unload_low();
        p.unload_high();
        done("fill_drain");
    endtask

    task automatic t_gate();
        p.load(wd(20), 1'b0, 1'b0);
        chk(output_ready, 1'b0);
        p.load(wd(21), 1'b1, 1'b1);
        chk(output_ready, 1'b1);
        chk(data_out, wd(21));
        done("gate");
    endtask

    task automatic t_oe();
        @(posedge ref_clk_i);
        data_oe_n <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        #1;
        chk(oe_n, 5'h1f);
        chk(output_ready, 1'b1);
        @(posedge ref_clk_i);
        data_oe_n <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
        chk(oe_n, 5'h00);
        chk(data_out, wd(21));
        done("oe");
    endtask

    task automatic t_clear();
        p.load(wd(22), 1'b0, 1'b1);
        @(posedge ref_clk_i);
        clear_all_n <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
        chk(output_ready, 1'b0);
        @(posedge ref_clk_i);
        clear_all_n <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        #1;
        chk(input_ready, 1'b1);
        p.load(wd(23), 1'b1, 1'b1);
        chk(output_ready, 1'b1);
        chk(data_out, wd(23));
        p.unload_low();
        p.unload_high();
        chk(output_ready, 1'b0);
        done("clear");
    endtask

    // ==========================================
    // main sequence and watchdog
    initial begin
        errors      = 0;
        n_checks    = 0;
        vac_lows    = 0;
        rst_i       = 1'b1;
        clear_all_n = 1'b1;
        data_oe_n   = 1'b0;
        repeat (5) @(posedge ref_clk_i);
        #1;
        t_reset();
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_fill_drain();
        t_gate();
        t_oe();
        t_clear();
        wrap_up();
    end

    initial begin
        #(6000 * 50);
        errors++;
        wrap_up();
    end
endmodule
